// File: rtl/tlic_defs.vh
// Purpose: Constants for the two-level interrupt controller
// Assumes: Special-function register port of an 8-bit core
// Notes: Included by the controller module only
`ifndef TLIC_DEFS_VH
`define TLIC_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TLIC_ADDR_IEN 8'hA8
`define TLIC_ADDR_SEC 8'hA9
`define TLIC_ADDR_LVL 8'hB8
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define TLIC_RST_IEN 8'h00
`define TLIC_RST_SEC 8'hA0
`define TLIC_RST_LVL 8'h00
`define TLIC_MASK_LVL 8'h7F
`define TLIC_MASK_SEC 8'hF7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TLIC_BIT_GLOBAL 7
`define TLIC_BIT_ADC 6
`define TLIC_BIT_T2 5
`define TLIC_BIT_UART 4
`define TLIC_BIT_T1 3
`define TLIC_BIT_X1 2
`define TLIC_BIT_T0 1
`define TLIC_BIT_X0 0
`define TLIC_BIT_TI_LVL 6
`define TLIC_BIT_PSM_LVL 5
`define TLIC_BIT_SIF_LVL 4
`define TLIC_BIT_TI_EN 2
`define TLIC_BIT_PSM_EN 1
`define TLIC_BIT_SIF_EN 0
// ----------------------------------------
// Source indices in poll order, 0 is polled first
// ----------------------------------------
`define TLIC_SRC_PSM 0
`define TLIC_SRC_WDT 1
`define TLIC_SRC_X0 2
`define TLIC_SRC_ADC 3
`define TLIC_SRC_T0 4
`define TLIC_SRC_X1 5
`define TLIC_SRC_T1 6
`define TLIC_SRC_SIF 7
`define TLIC_SRC_UART 8
`define TLIC_SRC_T2 9
`define TLIC_SRC_TI 10
`define TLIC_NSRC 11
// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define TLIC_VEC_X0 16'h0003
`define TLIC_VEC_T0 16'h000B
`define TLIC_VEC_X1 16'h0013
`define TLIC_VEC_T1 16'h001B
`define TLIC_VEC_UART 16'h0023
`define TLIC_VEC_T2 16'h002B
`define TLIC_VEC_ADC 16'h0033
`define TLIC_VEC_SIF 16'h003B
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TI 16'h0053
`define TLIC_VEC_WDT 16'h005B
`endif

// File: rtl/tlic_ctrl.v
// Purpose: Two-level interrupt controller with poll order and nesting
// Assumes: Core drives a one-cycle SFR write/read and ack/return pulses
// Notes: Timer 2 counting is outside; only its request flags live here
//
// How it works
// - Eleven sources, each high or low
// - Global bit 7 gates all maskable sources
// - Enable bits 6..0 gate seven main sources
// - Level bits 6..0 pick high/low; 7 reserved
// - Secondary bits 6..4 set extra levels
// - Secondary bits 2..0 enable extra sources
// - High request preempts low routine, one deep
// - Simultaneous: high level served first
// - Active level blocks same-level requests
// - Same level resolved by fixed poll order
// - Core pushes PC then loads vector
// - Each source has its fixed vector
// - Overflow flag set by hardware, blocked by baud
// - External flag set on trigger falling edge
// - Watchdog request bypasses global, high level
`timescale 1ns/10ps
`include "tlic_defs.vh"
module tlic_ctrl
(
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    // Register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output reg sfr_hit,
    // Source requests, levels from on-chip logic
    input wire supply_monitor_request,
    input wire watchdog_request,
    input wire watchdog_irq_mode,
    input wire ext0_request,
    input wire adc_request,
    input wire timer0_request,
    input wire ext1_request,
    input wire timer1_request,
    input wire serial_if_request,
    input wire uart_request,
    input wire interval_request,
    // Timer 2 flag sources
    input wire timer2_overflow,
    input wire timer2_trigger_pin,
    input wire timer2_external_enable,
    input wire tx_baud_select,
    input wire rx_baud_select,
    input wire timer2_flag_clear_ovf,
    input wire timer2_flag_clear_ext,
    // Core handshake
    input wire irq_ack,
    input wire irq_return,
    output reg irq_req,
    output reg [15:0] irq_vector,
    output reg [3:0] irq_source,
    output reg timer2_overflow_flag,
    output reg timer2_external_flag,
    output reg in_service_high,
    output reg in_service_low
);

// ----------------------------------------
// Local state
// ----------------------------------------
reg [7:0] ien_reg; // Main enable register
reg [7:0] lvl_reg; // Main level register
reg [7:0] sec_reg; // Secondary control register
reg [1:0] trig_sync_reg; // Trigger pin synchroniser
reg trig_prev_reg; // Previous synchronised trigger level
reg [10:0] pend; // Enabled requests
reg [10:0] high; // Level of each source
reg [10:0] sel_high;
reg [10:0] sel_low;
reg [10:0] cand;
reg take_high;
reg [3:0] win;
wire trig_fall;

// ----------------------------------------
// Helpers
// ----------------------------------------
// Lowest set index wins, matching poll order
function [3:0] first_set;
    input [10:0] v;
    integer i;
    begin
        first_set = 4'hF;
        for (i = `TLIC_NSRC - 1; i >= 0; i = i - 1)
        begin
            if (v[i])
            begin
                first_set = i[3:0];
            end
        end
    end
endfunction

// Vector lookup per source index
function [15:0] vec_of;
    input [3:0] s;
    begin
        case (s)
            `TLIC_SRC_PSM: vec_of = `TLIC_VEC_PSM;
            `TLIC_SRC_WDT: vec_of = `TLIC_VEC_WDT;
            `TLIC_SRC_X0: vec_of = `TLIC_VEC_X0;
            `TLIC_SRC_ADC: vec_of = `TLIC_VEC_ADC;
            `TLIC_SRC_T0: vec_of = `TLIC_VEC_T0;
            `TLIC_SRC_X1: vec_of = `TLIC_VEC_X1;
            `TLIC_SRC_T1: vec_of = `TLIC_VEC_T1;
            `TLIC_SRC_SIF: vec_of = `TLIC_VEC_SIF;
            `TLIC_SRC_UART: vec_of = `TLIC_VEC_UART;
            `TLIC_SRC_T2: vec_of = `TLIC_VEC_T2;
            default: vec_of = `TLIC_VEC_TI;
        endcase
    end
endfunction

assign trig_fall = trig_prev_reg & ~trig_sync_reg[1];

// ----------------------------------------
// Request gating and arbitration
// ----------------------------------------
// Enable, level and blocking per source
always @*
begin
    pend = 11'h000;
    high = 11'h000;
    // Maskable sources need global bit
    if (ien_reg[`TLIC_BIT_GLOBAL])
    begin
        // Main enable bits
        pend[`TLIC_SRC_ADC] = adc_request & ien_reg[`TLIC_BIT_ADC];
        pend[`TLIC_SRC_T2] = (timer2_overflow_flag | timer2_external_flag)
                             & ien_reg[`TLIC_BIT_T2];
        pend[`TLIC_SRC_UART] = uart_request & ien_reg[`TLIC_BIT_UART];
        pend[`TLIC_SRC_T1] = timer1_request & ien_reg[`TLIC_BIT_T1];
        pend[`TLIC_SRC_X1] = ext1_request & ien_reg[`TLIC_BIT_X1];
        pend[`TLIC_SRC_T0] = timer0_request & ien_reg[`TLIC_BIT_T0];
        pend[`TLIC_SRC_X0] = ext0_request & ien_reg[`TLIC_BIT_X0];
        // Secondary enable bits
        pend[`TLIC_SRC_TI] = interval_request & sec_reg[`TLIC_BIT_TI_EN];
        pend[`TLIC_SRC_PSM] = supply_monitor_request & sec_reg[`TLIC_BIT_PSM_EN];
        pend[`TLIC_SRC_SIF] = serial_if_request & sec_reg[`TLIC_BIT_SIF_EN];
    end
    // Watchdog ignores global enable
    pend[`TLIC_SRC_WDT] = watchdog_request & watchdog_irq_mode;
    high[`TLIC_SRC_WDT] = 1'b1;
    // Main level bits
    high[`TLIC_SRC_ADC] = lvl_reg[`TLIC_BIT_ADC];
    high[`TLIC_SRC_T2] = lvl_reg[`TLIC_BIT_T2];
    high[`TLIC_SRC_UART] = lvl_reg[`TLIC_BIT_UART];
    high[`TLIC_SRC_T1] = lvl_reg[`TLIC_BIT_T1];
    high[`TLIC_SRC_X1] = lvl_reg[`TLIC_BIT_X1];
    high[`TLIC_SRC_T0] = lvl_reg[`TLIC_BIT_T0];
    high[`TLIC_SRC_X0] = lvl_reg[`TLIC_BIT_X0];
    // Secondary level bits
    high[`TLIC_SRC_TI] = sec_reg[`TLIC_BIT_TI_LVL];
    high[`TLIC_SRC_PSM] = sec_reg[`TLIC_BIT_PSM_LVL];
    high[`TLIC_SRC_SIF] = sec_reg[`TLIC_BIT_SIF_LVL];
    // High blocked only by high in service
    sel_high = (in_service_high) ? 11'h000 : (pend & high);
    // Low blocked by any routine in service
    sel_low = (in_service_high | in_service_low) ? 11'h000 : (pend & ~high);
    // High level wins over low
    take_high = |sel_high;
    cand = take_high ? sel_high : sel_low;
    win = first_set(cand);
end

// ----------------------------------------
// Registers, flags and nesting state
// ----------------------------------------
// Everything holds while the clock enable is low
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        ien_reg <= `TLIC_RST_IEN;
        lvl_reg <= `TLIC_RST_LVL;
        sec_reg <= `TLIC_RST_SEC;
        trig_sync_reg <= 2'h0;
        trig_prev_reg <= 1'b0;
        timer2_overflow_flag <= 1'b0;
        timer2_external_flag <= 1'b0;
        in_service_high <= 1'b0;
        in_service_low <= 1'b0;
        irq_req <= 1'b0;
        irq_vector <= 16'h0000;
        irq_source <= 4'hF;
        sfr_rdata <= 8'h00;
        sfr_hit <= 1'b0;
    end
    else if (clk_en)
    begin
        trig_sync_reg <= {trig_sync_reg[0], timer2_trigger_pin};
        trig_prev_reg <= trig_sync_reg[1];
        // Register writes
        if (sfr_wr)
        begin
            case (sfr_addr)
                `TLIC_ADDR_IEN: ien_reg <= sfr_wdata;
                `TLIC_ADDR_LVL: lvl_reg <= sfr_wdata & `TLIC_MASK_LVL;
                // Bit 3 forced zero; software must keep it so
                `TLIC_ADDR_SEC: sec_reg <= sfr_wdata & `TLIC_MASK_SEC;
                default: ;
            endcase
        end
        // Register reads, answered next cycle
        sfr_hit <= sfr_rd & ((sfr_addr == `TLIC_ADDR_IEN) |
                   (sfr_addr == `TLIC_ADDR_LVL) | (sfr_addr == `TLIC_ADDR_SEC));
        case (sfr_addr)
            `TLIC_ADDR_IEN: sfr_rdata <= sfr_rd ? ien_reg : 8'h00;
            `TLIC_ADDR_LVL: sfr_rdata <= sfr_rd ? lvl_reg : 8'h00;
            `TLIC_ADDR_SEC: sfr_rdata <= sfr_rd ? sec_reg : 8'h00;
            default: sfr_rdata <= 8'h00;
        endcase
        // Overflow flag; set wins over clear
        if (timer2_overflow & ~tx_baud_select & ~rx_baud_select)
        begin
            timer2_overflow_flag <= 1'b1;
        end
        else if (timer2_flag_clear_ovf)
        begin
            timer2_overflow_flag <= 1'b0;
        end
        // External flag; baud use disables trigger events
        if (trig_fall & timer2_external_enable & ~tx_baud_select & ~rx_baud_select)
        begin
            timer2_external_flag <= 1'b1;
        end
        else if (timer2_flag_clear_ext)
        begin
            timer2_external_flag <= 1'b0;
        end
        // Present winner to the core
        irq_req <= (win != 4'hF) & ~irq_ack;
        irq_source <= win;
        irq_vector <= (win != 4'hF) ? vec_of(win) : 16'h0000;
        // Core pushes PC and jumps on ack; mark level
        if (irq_ack & irq_req)
        begin
            if (high[irq_source])
            begin
                in_service_high <= 1'b1;
            end
            else
            begin
                in_service_low <= 1'b1;
            end
        end
        else if (irq_return)
        begin
            // Exit innermost level first
            if (in_service_high)
            begin
                in_service_high <= 1'b0;
            end
            else
            begin
                in_service_low <= 1'b0;
            end
        end
    end
end

endmodule // tlic_ctrl

// File: verification/tlic_asserts.sv
// Purpose: Port-level timing checks for the interrupt controller
// Assumes: One clock domain, rst_n asynchronous and active low
// Notes: Bound to tlic_ctrl from the bench top
`timescale 1ns/10ps
module tlic_asserts
(
    input wire logic clock, rst_n, clk_en, sfr_rd, sfr_hit,
    input wire logic [7:0] sfr_addr, sfr_rdata,
    input wire logic irq_ack, irq_return, irq_req, in_service_high, in_service_low,
    input wire logic [15:0] irq_vector,
    input wire logic [3:0] irq_source,
    input wire logic watchdog_request, watchdog_irq_mode, timer2_overflow,
    input wire logic tx_baud_select, rx_baud_select, timer2_overflow_flag
);
    // Vector per poll index, index 0 in the low bits
    localparam logic [175:0] vec = {16'h0053, 16'h002B, 16'h0023, 16'h003B, 16'h001B,
        16'h0013, 16'h000B, 16'h0033, 16'h0003, 16'h005B, 16'h0043};
    // Overflow that the baud selects do not block
    wire ovf_ok = timer2_overflow && !tx_baud_select && !rx_baud_select;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_high_busy; in_service_high [*2]; endsequence
    sequence s_wdt_call; watchdog_request && watchdog_irq_mode && !in_service_high; endsequence
    vec_map_a: assert property (irq_req |->
        irq_vector == vec[irq_source*16 +: 16]) else $error("bad vector");
    read_hit_a: assert property (sfr_rd && clk_en |=>
        sfr_hit == ($past(sfr_addr) inside {8'hA8, 8'hA9, 8'hB8})) else $error("bad hit");
    high_block_a: assert property (s_high_busy |-> !irq_req)
        else $error("request in high routine");
    wdt_win_a: assert property (s_wdt_call ##0 !irq_ack |=>
        irq_req && irq_source <= 4'h1) else $error("watchdog not raised");
    ret_high_a: assert property (irq_return && !irq_ack && in_service_high |=>
        !in_service_high && in_service_low == $past(in_service_low)) else $error("high return");
    ret_low_a: assert property (irq_return && !irq_ack && !in_service_high |=>
        !in_service_low) else $error("low return");
    ovf_set_a: assert property (ovf_ok |=> timer2_overflow_flag)
        else $error("overflow flag not set");
    ovf_hold_a: assert property (!timer2_overflow_flag && !ovf_ok |=>
        !timer2_overflow_flag) else $error("overflow flag rose");
endmodule // tlic_asserts

// File: verification/tlic_core_model.sv
// Purpose: Core that takes, nests and returns from interrupts
// Assumes: Acks only while a request stands
// Notes: Delay and return are commanded by the bench
`timescale 1ns/10ps
module tlic_core_model
(
    input wire clock, rst_n, irq_req, ret_go,
    input wire [3:0] dly,
    output reg irq_ack, irq_return,
    output reg [3:0] depth
);
    reg [3:0] wait_reg; // Cycles the request has waited
    // Slow answers come from dly; no second ack on a stale request
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            wait_reg <= 4'h0;
            depth <= 4'h0;
        end
        else
        begin
            irq_ack <= irq_req && !irq_ack && wait_reg >= dly;
            wait_reg <= (irq_req && !irq_ack) ? wait_reg + 4'h1 : 4'h0;
            irq_return <= ret_go && depth != 4'h0;
            depth <= depth + irq_ack - irq_return;
        end
    end
endmodule // tlic_core_model

// File: verification/tb.sv
// Purpose: Bench for the two-level interrupt controller
// Assumes: Core model answers requests; sources driven here
// Notes: Drives on rising edges, samples on falling edges
`timescale 1ns/10ps
module tb;
    reg clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ret_go = 1'b0;
    reg watchdog_irq_mode = 1'b0, timer2_overflow = 1'b0, timer2_trigger_pin = 1'b1;
    reg timer2_external_enable = 1'b0, tx_baud_select = 1'b0, rx_baud_select = 1'b0;
    reg timer2_flag_clear_ovf = 1'b0, timer2_flag_clear_ext = 1'b0;
    reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    reg [10:0] rq = 11'h000; // Requests in poll order, bit 9 unused
    reg [3:0] dly = 4'h0;
    reg clk_en = 1'b1; // Freeze control, dropped once to check the hold
    wire [7:0] sfr_rdata;
    wire sfr_hit, irq_req, irq_ack, irq_return, in_service_high, in_service_low;
    wire timer2_overflow_flag, timer2_external_flag;
    wire [15:0] irq_vector;
    wire [3:0] irq_source, depth;
    reg [175:0] vec = {16'h0053, 16'h002B, 16'h0023, 16'h003B, 16'h001B,
        16'h0013, 16'h000B, 16'h0033, 16'h0003, 16'h005B, 16'h0043};
    integer errors = 0, n_checks = 0, j;
    always #5 clock = ~clock;
    tlic_ctrl i_tlic_ctrl (.*, .supply_monitor_request(rq[0]),
        .watchdog_request(rq[1]), .ext0_request(rq[2]), .adc_request(rq[3]),
        .timer0_request(rq[4]), .ext1_request(rq[5]), .timer1_request(rq[6]),
        .serial_if_request(rq[7]), .uart_request(rq[8]), .interval_request(rq[10]));
    tlic_core_model i_tlic_core_model (.*);
    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("wrong value %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] e, input h);
    begin
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        @(negedge clock);
        chk("rdata", e, sfr_rdata);
        chk("hit", h, sfr_hit);
    end
    endtask
    // Wait for the request, compare it, then wait for the core to take it
    task take(input integer s);
        integer k;
    begin
        // Never look at outputs in the time step of the launching edge
        @(negedge clock);
        for (k = 0; k < 40 && irq_req !== 1'b1; k = k + 1)
            @(negedge clock);
        chk("source", s, irq_source);
        chk("vector", vec[s*16 +: 16], irq_vector);
        for (k = 0; k < 40 && irq_ack !== 1'b1; k = k + 1)
            @(negedge clock);
        @(posedge clock);
    end
    endtask
    task leave;
    begin
        @(posedge clock);
        ret_go <= 1'b1;
        @(posedge clock);
        ret_go <= 1'b0;
        repeat (2) @(negedge clock);
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'hA8, 8'h00, 1'b1);
        rd(8'hA9, 8'hA0, 1'b1);
        rd(8'hC8, 8'h00, 1'b0);
        wr(8'hB8, 8'hFF);
        rd(8'hB8, 8'h7F, 1'b1);
        wr(8'hA9, 8'hF7);
        rd(8'hA9, 8'hF7, 1'b1);
        wr(8'hA9, 8'h07);
        wr(8'hB8, 8'h00);
        wr(8'hA8, 8'h7F);
        rq <= 11'h5FD;
        repeat (5) @(negedge clock);
        chk("req", 1'b0, irq_req);
        wr(8'hA8, 8'hFF);
        for (j = 0; j < 11; j = j + 1)
        begin
            if (j != 1 && j != 9)
            begin
                take(j);
                rq[j] <= 1'b0;
                leave;
            end
        end
        // Slow core: low routine, same-level block, high preempts
        wr(8'hA8, 8'h98);
        dly <= 4'h3;
        rq[8] <= 1'b1;
        take(8);
        rq[6] <= 1'b1;
        repeat (4) @(negedge clock);
        chk("blocked", 1'b0, irq_req);
        @(posedge clock);
        watchdog_irq_mode <= 1'b1;
        rq[1] <= 1'b1;
        take(1);
        rq[1] <= 1'b0;
        leave;
        chk("high", 1'b0, in_service_high);
        chk("low", 1'b1, in_service_low);
        @(posedge clock);
        rq[8] <= 1'b0;
        leave;
        take(6);
        rq[6] <= 1'b0;
        leave;
        // Same-cycle requests of both levels
        dly <= 4'h0;
        wr(8'hB8, 8'h10);
        wr(8'hA8, 8'h92);
        rq[4] <= 1'b1;
        rq[8] <= 1'b1;
        take(8);
        rq[8] <= 1'b0;
        leave;
        take(4);
        rq[4] <= 1'b0;
        leave;
        wr(8'hA8, 8'h00);
        rq[1] <= 1'b1;
        take(1);
        rq[1] <= 1'b0;
        leave;
        // Clock enable low: a write must not land
        @(posedge clock);
        clk_en <= 1'b0;
        wr(8'hB8, 8'h7F);
        clk_en <= 1'b1;
        rd(8'hB8, 8'h10, 1'b1);
        for (j = 1; j < 3; j = j + 1)
        begin
            @(posedge clock);
            {tx_baud_select, rx_baud_select} <= j[1:0];
            @(posedge clock);
            timer2_overflow <= 1'b1;
            @(posedge clock);
            timer2_overflow <= 1'b0;
            @(negedge clock);
            chk("ovf", 1'b0, timer2_overflow_flag);
        end
        @(posedge clock);
        {tx_baud_select, rx_baud_select} <= 2'b00;
        timer2_overflow <= 1'b1;
        @(posedge clock);
        timer2_overflow <= 1'b0;
        wr(8'hA8, 8'hA0);
        take(9);
        timer2_flag_clear_ovf <= 1'b1;
        @(posedge clock);
        timer2_flag_clear_ovf <= 1'b0;
        leave;
        chk("ovf", 1'b0, timer2_overflow_flag);
        @(posedge clock);
        timer2_external_enable <= 1'b1;
        timer2_trigger_pin <= 1'b0;
        take(9);
        timer2_flag_clear_ext <= 1'b1;
        @(posedge clock);
        timer2_flag_clear_ext <= 1'b0;
        leave;
        chk("ext", 1'b0, timer2_external_flag);
        print_verdict;
    end
    // Hang guard, about fifty times the expected run
    initial
    begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
endmodule // tb
bind tlic_ctrl tlic_asserts i_tlic_asserts (.*);
